//--- shared/vicc_pkg.sv
// Constants for the video input clamp and sync control block.
// Assumes a single mclk domain; plain-port configuration, no bus.
package vicc_pkg;
    // Configuration bit positions, kept for firmware reference
    localparam int CFG_MODE_ADDR = 8'h10;
    localparam int MODE_COMPONENT_BIT = 4;
    localparam int MODE_DC_COUPLE_BIT = 3;
    localparam int DECIM_ADDR = 8'h28;
    localparam int DECIM_BIT = 0;
    localparam int CLAMP_START_LO_ADDR = 8'h24;
    localparam int CLAMP_START_HI_ADDR = 8'h25;
    localparam int CLAMP_WIDTH_ADDR = 8'h26;
    localparam int COAST_CLAMP_ADDR = 8'h60;
    localparam int COAST_CLAMP_BIT = 2;
    localparam int SOG_THRESH_ADDR = 8'h30;
    localparam int SOG_FILTER_ADDR = 8'h31;
    localparam int MASK_DIS_ADDR = 8'h7A;
    localparam int MASK_DIS_BIT = 4;
    localparam int LOOP_GAIN_ADDR = 8'h74;
    // Values
    localparam logic [7:0] MIDSCALE = 8'h80;
    localparam logic [7:0] BLACK_CODE = 8'h00;
    localparam logic [7:0] LOOP_GAIN_DEFAULT = 8'h49;
    localparam logic [7:0] LOOP_GAIN_TAPE = 8'h4C;
    localparam logic [15:0] TRI_LEVEL_MIN_START = 16'h0030;
    localparam int SOG_THRESH_W = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int PIX_W = 8;
    localparam int LANES_W = 3 * PIX_W;
    // Tri-level detect: green below this code counts as a low sync tip
    localparam logic [7:0] TRI_LOW_CODE = 8'h10;
    localparam logic [7:0] TRI_HIGH_CODE = 8'hC0;
    // Copy-protection detect: more than this many extra sync pulses in one frame
    localparam logic [3:0] CP_PULSE_LIMIT = 4'h2;
    // Activity: a source is active if it toggled within this many clocks
    localparam logic [15:0] ACT_WINDOW = 16'hFFFF;

    typedef enum logic [1:0] {
        VICC_SRC_SEPARATE = 2'b00,
        VICC_SRC_COMPOSITE = 2'b01,
        VICC_SRC_SOG = 2'b10
    } vicc_src_t;

    typedef enum logic [1:0] {
        VICC_CL_IDLE = 2'b00,
        VICC_CL_DELAY = 2'b01,
        VICC_CL_ON = 2'b10
    } vicc_clamp_t;
endpackage

//--- logic/vicc_fifo.sv
// Synchronous FIFO for pixel words.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module vicc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (count != '0);
    assign out_data = mem[rptr];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (pop) begin
                rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- logic/vicc_core.sv
// Assumes pixel-rate samples and sync on mclk; pins pass a 3-stage sync.
`timescale 1ns/1ps
module vicc_core #(
    parameter int START_W = 16,
    parameter int WIDTH_W = 8
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic mode_component,
    input wire logic mode_dc_couple,
    input wire logic decimate,
    input wire logic clamp_in_coast,
    input wire logic sync_mask_disable,
    input wire logic [START_W-1:0] clamp_start,
    input wire logic [WIDTH_W-1:0] clamp_width,
    input wire logic [vicc_pkg::SOG_THRESH_W-1:0] sync_on_green_thresh,
    input wire logic sync_on_green_hyst,
    input wire logic sync_on_green_lpf,
    input wire logic [1:0] sync_source,
    input wire logic [7:0] loop_gain,
    input wire logic line_sync_pin,
    input wire logic frame_sync_pin,
    input wire logic sync_on_green_pin,
    input wire logic pixel_phase_loop_coast,
    input wire logic pix_valid,
    input wire logic [vicc_pkg::PIX_W-1:0] pix_red,
    input wire logic [vicc_pkg::PIX_W-1:0] pix_green,
    input wire logic [vicc_pkg::PIX_W-1:0] pix_blue,
    output logic pix_in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [vicc_pkg::PIX_W-1:0] out_red,
    output logic [vicc_pkg::PIX_W-1:0] out_green,
    output logic [vicc_pkg::PIX_W-1:0] out_blue,
    output logic [vicc_pkg::PIX_W-1:0] black_red,
    output logic [vicc_pkg::PIX_W-1:0] black_blue,
    output logic dc_restore_clamp,
    output logic black_avg_start,
    output logic loop_sync,
    output logic line_sync_out,
    output logic [vicc_pkg::SOG_THRESH_W-1:0] slicer_thresh,
    output logic slicer_hyst,
    output logic slicer_lpf,
    output logic [7:0] loop_gain_out,
    output logic act_line,
    output logic act_frame,
    output logic act_sync_on_green,
    output logic tri_level_seen,
    output logic copy_protect_seen
);
    import vicc_pkg::*;

    // Pin synchronisers: three stages, change taken when 2 and 3 agree
    logic [2:0] ls_sh;
    logic [2:0] fs_sh;
    logic [2:0] sg_sh;
    logic ls_f;
    logic fs_f;
    logic sg_f;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ls_sh <= 3'h0;
            fs_sh <= 3'h0;
            sg_sh <= 3'h0;
        end else begin
            ls_sh <= {ls_sh[1:0], line_sync_pin};
            fs_sh <= {fs_sh[1:0], frame_sync_pin};
            sg_sh <= {sg_sh[1:0], sync_on_green_pin};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ls_f <= 1'b0;
            fs_f <= 1'b0;
            sg_f <= 1'b0;
        end else begin
            if (ls_sh[1] == ls_sh[2]) ls_f <= ls_sh[2];
            if (fs_sh[1] == fs_sh[2]) fs_f <= fs_sh[2];
            if (sg_sh[1] == sg_sh[2]) sg_f <= sg_sh[2];
        end
    end

    // Chosen sync source and its trailing edge (active high pulse)
    logic sel_sync;
    logic sel_sync_d;
    logic trail;
    logic sg_f_d;
    logic ls_f_d;
    logic fs_f_d;

    always_comb begin
        unique case (vicc_src_t'(sync_source))
            VICC_SRC_SOG: sel_sync = sg_f;
            default: sel_sync = ls_f;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sel_sync_d <= 1'b0;
            sg_f_d <= 1'b0;
            ls_f_d <= 1'b0;
            fs_f_d <= 1'b0;
        end else begin
            sel_sync_d <= sel_sync;
            sg_f_d <= sg_f;
            ls_f_d <= ls_f;
            fs_f_d <= fs_f;
        end
    end
    assign trail = sel_sync_d && !sel_sync;

    // Activity detect per source
    logic [15:0] act_cnt_l;
    logic [15:0] act_cnt_f;
    logic [15:0] act_cnt_s;

    function automatic logic [15:0] act_next(input logic [15:0] c,
                                             input logic edge_seen);
        if (edge_seen) return 16'h0000;
        if (c != ACT_WINDOW) return c + 16'h0001;
        return c;
    endfunction

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            act_cnt_l <= ACT_WINDOW;
            act_cnt_f <= ACT_WINDOW;
            act_cnt_s <= ACT_WINDOW;
            act_line <= 1'b0;
            act_frame <= 1'b0;
            act_sync_on_green <= 1'b0;
        end else begin
            act_cnt_l <= act_next(act_cnt_l, ls_f != ls_f_d);
            act_cnt_f <= act_next(act_cnt_f, fs_f != fs_f_d);
            act_cnt_s <= act_next(act_cnt_s, sg_f != sg_f_d);
            act_line <= (act_cnt_l != ACT_WINDOW);
            act_frame <= (act_cnt_f != ACT_WINDOW);
            act_sync_on_green <= (act_cnt_s != ACT_WINDOW);
        end
    end

    // Copy-protection detect: extra sync pulses within one frame
    logic [3:0] cp_pulses;
    logic cp_mask;
    logic green_lead;
    assign green_lead = sg_f && !sg_f_d;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cp_pulses <= 4'h0;
            cp_mask <= 1'b1;
            copy_protect_seen <= 1'b0;
        end else begin
            if (fs_f && !fs_f_d) begin
                copy_protect_seen <= (cp_pulses > CP_PULSE_LIMIT);
                cp_pulses <= 4'h0;
            end else if (green_lead && pixel_phase_loop_coast
                         && cp_pulses != 4'hF) begin
                cp_pulses <= cp_pulses + 4'h1;
            end
            // Mask drops pulses while the loop coasts once copy protection was seen
            cp_mask <= !(copy_protect_seen && pixel_phase_loop_coast);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            loop_sync <= 1'b0;
            line_sync_out <= 1'b0;
        end else begin
            loop_sync <= (sync_source == VICC_SRC_SOG) ? (sg_f & cp_mask)
                                                        : ls_f;
            line_sync_out <= sync_mask_disable ? sel_sync
                                               : (sel_sync & cp_mask);
        end
    end

    // Slicer and loop-gain settings pass to the analog side
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            slicer_thresh <= '0;
            slicer_hyst <= 1'b0;
            slicer_lpf <= 1'b0;
            loop_gain_out <= LOOP_GAIN_DEFAULT;
        end else begin
            slicer_thresh <= sync_on_green_thresh;
            slicer_hyst <= sync_on_green_hyst;
            slicer_lpf <= sync_on_green_lpf;
            loop_gain_out <= loop_gain;
        end
    end

    // Clamp timing; settings latched at trailing edge
    vicc_clamp_t cl_state;
    logic [WIDTH_W-1:0] width_lat;
    logic [START_W-1:0] cl_cnt;
    logic line_coasted;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            width_lat <= '0;
        end else if (trail && cl_state != VICC_CL_ON) begin
            width_lat <= clamp_width;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            line_coasted <= 1'b0;
        end else if (trail) begin
            line_coasted <= pixel_phase_loop_coast;
        end else if (pixel_phase_loop_coast) begin
            line_coasted <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cl_state <= VICC_CL_IDLE;
            cl_cnt <= '0;
            dc_restore_clamp <= 1'b0;
            black_avg_start <= 1'b0;
        end else begin
            black_avg_start <= 1'b0;
            unique case (cl_state)
                VICC_CL_IDLE: begin
                    if (trail) begin
                        cl_state <= VICC_CL_DELAY;
                        cl_cnt <= clamp_start;
                    end
                end
                VICC_CL_DELAY: begin
                    if (pix_valid) begin
                        if (cl_cnt <= START_W'(1)) begin
                            black_avg_start <= 1'b1;
                            if (!mode_dc_couple && width_lat != '0
                                && !(line_coasted && !clamp_in_coast)) begin
                                cl_state <= VICC_CL_ON;
                                dc_restore_clamp <= 1'b1;
                                cl_cnt <= START_W'(width_lat);
                            end else begin
                                cl_state <= VICC_CL_IDLE;
                            end
                        end else begin
                            cl_cnt <= cl_cnt - START_W'(1);
                        end
                    end
                end
                VICC_CL_ON: begin
                    if (pix_valid) begin
                        if (cl_cnt == START_W'(1)) begin
                            cl_state <= VICC_CL_IDLE;
                            dc_restore_clamp <= 1'b0;
                        end else begin
                            cl_cnt <= cl_cnt - START_W'(1);
                        end
                    end
                end
                default: cl_state <= VICC_CL_IDLE;
            endcase
        end
    end

    // Tri-level detect on green samples while sync is asserted
    logic saw_low;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            saw_low <= 1'b0;
            tri_level_seen <= 1'b0;
        end else if (trail) begin
            saw_low <= 1'b0;
        end else if (pix_valid && sel_sync) begin
            if (pix_green < TRI_LOW_CODE) saw_low <= 1'b1;
            if (saw_low && pix_green > TRI_HIGH_CODE) tri_level_seen <= 1'b1;
        end
    end

    // Black level codes per mode
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            black_red <= BLACK_CODE;
            black_blue <= BLACK_CODE;
        end else begin
            black_red <= mode_component ? MIDSCALE : BLACK_CODE;
            black_blue <= mode_component ? MIDSCALE : BLACK_CODE;
        end
    end

    // Lane mapping into the FIFO; no colour math on purpose
    logic phase_odd;
    logic [PIX_W-1:0] u_hold;
    logic [LANES_W-1:0] map_word;
    logic push_ok;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            phase_odd <= 1'b0;
            u_hold <= '0;
        end else if (trail) begin
            phase_odd <= 1'b0;
        end else if (pix_valid && push_ok) begin
            phase_odd <= !phase_odd;
            if (!phase_odd) u_hold <= pix_red;
        end
    end

    always_comb begin
        if (decimate) begin
            // Red gets V of even pixel, then U of same even pixel
            map_word = {phase_odd ? u_hold : pix_blue, pix_green,
                        BLACK_CODE};
        end else begin
            map_word = {pix_red, pix_green, pix_blue};
        end
    end

    logic [LANES_W-1:0] fifo_out;
    logic fifo_valid;

    vicc_fifo #(.WIDTH(LANES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(pix_valid),
        .in_ready(push_ok),
        .in_data(map_word),
        .out_valid(fifo_valid),
        .out_ready(!out_valid || out_ready),
        .out_data(fifo_out)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid <= 1'b0;
            out_red <= '0;
            out_green <= '0;
            out_blue <= '0;
            pix_in_ready <= 1'b0;
        end else begin
            pix_in_ready <= push_ok;
            if (!out_valid || out_ready) begin
                out_valid <= fifo_valid;
                {out_red, out_green, out_blue} <= fifo_out;
            end
        end
    end

    clamp_width_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(dc_restore_clamp) && width_lat == 8'h01 && pix_valid
        |=> !dc_restore_clamp)
        else $error("clamp longer than one pixel");
    dc_no_clamp_a: assert property (@(posedge mclk) disable iff (!arst_n)
        mode_dc_couple && $stable(mode_dc_couple) |=> !$rose(dc_restore_clamp))
        else $error("clamp in dc mode");
    coast_block_a: assert property (@(posedge mclk) disable iff (!arst_n)
        cl_state == VICC_CL_DELAY && line_coasted && !clamp_in_coast
        |=> !$rose(dc_restore_clamp))
        else $error("clamp while coasting");
    midscale_a: assert property (@(posedge mclk) disable iff (!arst_n)
        mode_component |=> black_red == MIDSCALE && black_blue == MIDSCALE)
        else $error("midscale missing");
    rgb_black_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !mode_component |=> black_red == BLACK_CODE)
        else $error("rgb black wrong");
    blue_low_a: assert property (@(posedge mclk) disable iff (!arst_n)
        decimate && pix_valid |-> map_word[PIX_W-1:0] == BLACK_CODE)
        else $error("blue not low");
    lane_map_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !decimate |-> map_word == {pix_red, pix_green, pix_blue})
        else $error("lane mismatch");
    mask_pass_a: assert property (@(posedge mclk) disable iff (!arst_n)
        sync_mask_disable |=> line_sync_out == $past(sel_sync))
        else $error("mask not bypassed");
    sog_mask_a: assert property (@(posedge mclk) disable iff (!arst_n)
        sync_source == VICC_SRC_SOG && !cp_mask |=> !loop_sync)
        else $error("masked sync reached loop");
    avg_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(dc_restore_clamp) |-> black_avg_start)
        else $error("averaging not with clamp");
endmodule

//--- tb/vicc_src.sv
// Video source model: line sync pulses and a pixel stream.
// Assumes the bench owns mclk; drives on the falling edge.
`timescale 1ns/1ps
module vicc_src (
    input wire logic mclk,
    input wire logic pix_in_ready,
    output logic line_sync_pin,
    output logic pix_valid,
    output logic [7:0] pix_red,
    output logic [7:0] pix_green,
    output logic [7:0] pix_blue,
    output int stalls
);
    int idx = 0;
    initial begin
        line_sync_pin = 1'b0;
        pix_valid = 1'b0;
        pix_red = 8'h00;
        pix_green = 8'h00;
        pix_blue = 8'h00;
        stalls = 0;
    end
    task automatic sync_pulse(input int len);
        line_sync_pin = 1'b1;
        repeat (len) @(negedge mclk);
        line_sync_pin = 1'b0;
    endtask
    // Ready is registered: after an edge it says whether that edge took
    // the pixel, so a refused pixel is held for another edge
    task automatic send(input int n);
        int w;
        for (int i = 0; i < n; i++) begin
            pix_valid = 1'b1;
            pix_red = idx[7:0];
            pix_green = idx[7:0] + 8'h40;
            pix_blue = ~idx[7:0];
            w = 0;
            @(negedge mclk);
            while (pix_in_ready !== 1'b1 && w < 64) begin
                @(negedge mclk);
                w++;
            end
            if (w == 64)
                stalls++;
            idx++;
        end
        pix_valid = 1'b0;
        // Idle lanes must not keep showing the last pixel
        pix_red = ~pix_red;
        pix_green = ~pix_green;
        pix_blue = ~pix_blue;
    endtask
endmodule

//--- tb/tb_vicc_core.sv
// Bench for vicc_core: line timing, stream mapping and FIFO back-pressure.
// Assumes vicc_src supplies sync and pixels; one 40 MHz clock.
`timescale 1ns/1ps
module tb_vicc_core;
    import vicc_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic mode_component = 1'b0;
    logic mode_dc_couple = 1'b0;
    logic decimate = 1'b0;
    logic clamp_in_coast = 1'b0;
    logic sync_mask_disable = 1'b0;
    logic [15:0] clamp_start = 16'h0000;
    logic [7:0] clamp_width = 8'h00;
    logic [3:0] sync_on_green_thresh = 4'h0;
    logic sync_on_green_hyst = 1'b0;
    logic sync_on_green_lpf = 1'b0;
    logic [7:0] loop_gain = 8'h49;
    logic pixel_phase_loop_coast = 1'b0;
    logic out_ready = 1'b1;
    logic line_sync_pin, pix_valid, pix_in_ready, out_valid;
    logic [7:0] pix_red, pix_green, pix_blue, out_red, out_green, out_blue;
    logic [7:0] black_red, black_blue, loop_gain_out;
    logic [3:0] slicer_thresh;
    logic dc_restore_clamp, black_avg_start, line_sync_out;
    logic slicer_hyst, slicer_lpf, act_line;
    int stalls;
    int failures = 0;
    int check_count = 0;
    int n = 0;
    int since, c_at, c_len, avg_n, lso_n;
    logic [7:0] e;

    initial forever #12.5 mclk = ~mclk;

    vicc_src src (.mclk(mclk), .pix_in_ready(pix_in_ready),
        .line_sync_pin(line_sync_pin), .pix_valid(pix_valid),
        .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
        .stalls(stalls));

    vicc_core uut (.mclk(mclk), .arst_n(arst_n),
        .mode_component(mode_component), .mode_dc_couple(mode_dc_couple),
        .decimate(decimate), .clamp_in_coast(clamp_in_coast),
        .sync_mask_disable(sync_mask_disable), .clamp_start(clamp_start),
        .clamp_width(clamp_width),
        .sync_on_green_thresh(sync_on_green_thresh),
        .sync_on_green_hyst(sync_on_green_hyst),
        .sync_on_green_lpf(sync_on_green_lpf), .sync_source(2'b00),
        .loop_gain(loop_gain), .line_sync_pin(line_sync_pin),
        .frame_sync_pin(1'b0), .sync_on_green_pin(1'b0),
        .pixel_phase_loop_coast(pixel_phase_loop_coast),
        .pix_valid(pix_valid), .pix_red(pix_red), .pix_green(pix_green),
        .pix_blue(pix_blue), .pix_in_ready(pix_in_ready),
        .out_valid(out_valid), .out_ready(out_ready), .out_red(out_red),
        .out_green(out_green), .out_blue(out_blue), .black_red(black_red),
        .black_blue(black_blue), .dc_restore_clamp(dc_restore_clamp),
        .black_avg_start(black_avg_start), .loop_sync(),
        .line_sync_out(line_sync_out), .slicer_thresh(slicer_thresh),
        .slicer_hyst(slicer_hyst), .slicer_lpf(slicer_lpf),
        .loop_gain_out(loop_gain_out), .act_line(act_line), .act_frame(),
        .act_sync_on_green(), .tri_level_seen(), .copy_protect_seen());

    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test;
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Output n carries input pixel n; lines hold even counts and start
    // after the trail edge, so the decimation phase follows n
    always @(posedge mclk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            e = n[7:0];
            chk("out_green", 8'(e + 8'h40), out_green);
            if (decimate) begin
                chk("out_red", n % 2 ? 8'(e - 1) : 8'(~e), out_red);
                chk("out_blue", 8'h00, out_blue);
            end else begin
                chk("out_red", e, out_red);
                chk("out_blue", 8'(~e), out_blue);
            end
            n++;
        end
    end

    always @(posedge mclk) begin
        if (line_sync_pin) begin
            since = 0;
            c_at = -1;
            c_len = 0;
            avg_n = 0;
            lso_n = 0;
        end else
            since++;
        if (dc_restore_clamp === 1'b1) begin
            c_len++;
            if (c_at < 0)
                c_at = since;
        end
        avg_n += int'(black_avg_start === 1'b1);
        lso_n += int'(line_sync_out === 1'b1);
    end

    // Sync path adds a few clocks before the start count begins;
    // pixels wait for the trail edge, which resets the 4:2:2 phase
    task automatic line(input int st, input int wd, input int expw);
        clamp_start = st[15:0];
        clamp_width = wd[7:0];
        src.sync_pulse(4);
        repeat (8) @(negedge mclk);
        src.send(((st + wd + 21) / 2) * 2);
        repeat (12) @(negedge mclk);
        chk("clamp_len", expw[15:0], c_len[15:0]);
        chk("avg_start", 16'h0001, avg_n[15:0]);
        if (expw > 0)
            chk("clamp_at", 16'h0001, {15'h0, c_at >= st && c_at <= st + 12});
    endtask

    initial begin
        repeat (50000) @(posedge mclk);
        failures++;
        stop_test;
    end

    initial begin
        repeat (16) @(negedge mclk);
        arst_n = 1'b1;
        @(negedge mclk);
        chk("loop_gain_out", 16'h0049, loop_gain_out);
        chk("black_red", 16'h0000, black_red);
        sync_on_green_thresh = 4'hA;
        sync_on_green_hyst = 1'b1;
        sync_on_green_lpf = 1'b1;
        loop_gain = 8'h4C;
        mode_component = 1'b1;
        repeat (3) @(negedge mclk);
        chk("slicer_thresh", 16'h000A, slicer_thresh);
        chk("slicer_bits", 16'h0003, {slicer_hyst, slicer_lpf});
        chk("loop_gain_out", 16'h004C, loop_gain_out);
        chk("black_red", 16'h0080, black_red);
        chk("black_blue", 16'h0080, black_blue);
        line(5, 4, 4);
        line(300, 1, 1);
        line(49, 8, 8);
        chk("act_line", 16'h0001, act_line);
        sync_mask_disable = 1'b1;
        line(0, 2, 2);
        chk("line_sync_out", 16'h0001, {15'h0, lso_n > 0});
        mode_dc_couple = 1'b1;
        line(5, 4, 0);
        mode_dc_couple = 1'b0;
        pixel_phase_loop_coast = 1'b1;
        line(5, 4, 0);
        clamp_in_coast = 1'b1;
        line(5, 4, 4);
        pixel_phase_loop_coast = 1'b0;
        // Stall the sink so the buffer fills and refuses, then drain
        out_ready = 1'b0;
        fork
            src.send(20);
            begin
                repeat (40) @(negedge mclk);
                chk("pix_in_ready", 16'h0000, pix_in_ready);
                out_ready = 1'b1;
            end
        join
        repeat (30) @(negedge mclk);
        chk("drained", 16'h0001, {15'h0, n == src.idx});
        decimate = 1'b1;
        line(5, 4, 4);
        repeat (10) @(negedge mclk);
        chk("stalls", 16'h0000, stalls[15:0]);
        stop_test;
    end
endmodule
